// File: verilog/tcr_pkg.sv
// package: register map, command codes, busy times and carriers of the touch command block
// ****************************************************************
// Summary of operation
// - store, restore and default-write block access 120 ms
// - default and working-config reads block access 5 ms
// - codes 07 and 08 pick normal or setup
// - scan start blocks 10 ms, stop 5 ms, status none
// - sleep pin config writable only in setup mode
// - other registers accessible in both modes
// - reserved addresses read zero, ignore writes
// - nack the address until the full maximum time has run out
// - read-back registers ignore host writes
// - sleep and button select registers read and write
// ****************************************************************
`default_nettype none
package tcr_pkg;
	// ****************************************************************
	// register offsets and reset value
	// ****************************************************************
	localparam logic [7:0] REG_SLEEP_PIN = 8'h7E;
	localparam logic [7:0] REG_SLEEP_CTRL = 8'h7F;
	localparam logic [7:0] REG_SLEEP_CNT = 8'h80;
	localparam logic [7:0] REG_BTN_SEL = 8'h81;
	localparam logic [7:0] REG_BASE_HI = 8'h82;
	localparam logic [7:0] REG_BASE_LO = 8'h83;
	localparam logic [7:0] REG_DIFF_HI = 8'h84;
	localparam logic [7:0] REG_DIFF_LO = 8'h85;
	localparam logic [7:0] REG_RAW_HI = 8'h86;
	localparam logic [7:0] REG_RAW_LO = 8'h87;
	localparam logic [7:0] REG_STAT_HI = 8'h88;
	localparam logic [7:0] REG_STAT_LO = 8'h89;
	localparam logic [7:0] REG_COMMAND = 8'hA0;
	localparam logic [7:0] RSV_A_FIRST = 8'h75;
	localparam logic [7:0] RSV_A_LAST = 8'h78;
	localparam logic [7:0] RSV_B = 8'h7D;
	localparam logic [7:0] RSV_C_FIRST = 8'h8A;
	localparam logic [7:0] RSV_C_LAST = 8'h8D;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int unsigned CLK_KHZ = 25000;
	localparam int unsigned NVM_BUSY_MS = 120;
	localparam int unsigned CFG_BUSY_MS = 5;
	localparam int unsigned SCAN_START_MS = 10;
	localparam int unsigned SCAN_STOP_MS = 5;
	localparam int unsigned NVM_BUSY_CYC = NVM_BUSY_MS * CLK_KHZ;
	localparam int unsigned CFG_BUSY_CYC = CFG_BUSY_MS * CLK_KHZ;
	localparam int unsigned SCAN_START_CYC = SCAN_START_MS * CLK_KHZ;
	localparam int unsigned SCAN_STOP_CYC = SCAN_STOP_MS * CLK_KHZ;
	localparam int BUSY_W = 22;
	// ****************************************************************
	// command codes
	// ****************************************************************
	typedef enum logic [7:0] {
		CMD_FW_REV = 8'h00,
		CMD_STORE = 8'h01,
		CMD_FACTORY = 8'h02,
		CMD_WR_DEFAULTS = 8'h03,
		CMD_RD_DEFAULTS = 8'h04,
		CMD_RD_WORKING = 8'h05,
		CMD_RECONFIG = 8'h06,
		CMD_NORMAL = 8'h07,
		CMD_SETUP = 8'h08,
		CMD_SCAN_START = 8'h09,
		CMD_SCAN_STOP = 8'h0A,
		CMD_SCAN_STATUS = 8'h0B
	} tcr_cmd_e;
	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic [15:0] baseline;
		logic [15:0] difference;
		logic [15:0] raw_count;
		logic [15:0] sensor_state;
	} tcr_readback_s;
	typedef struct packed {
		logic [7:0] pin_config;
		logic [7:0] control;
		logic [7:0] standalone_counter;
		logic [7:0] button_select;
	} tcr_sleep_s;
endpackage
`default_nettype wire

// File: verilog/tcr_busy_timer.sv
// module: down counter that holds the device inaccessible after slow commands
`default_nettype none
`timescale 1ns/10ps
module tcr_busy_timer #(
	parameter int W = 22
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic sys_rst_in,
	// load
	input wire logic load_in,
	input wire logic [W-1:0] load_val_in,
	// state
	output logic busy_out,
	output logic [W-1:0] remain_out
);
	logic [W-1:0] next_remain;

	if (W < 2) begin : g_bad_width
		$error("busy timer width too small");
	end

	// a new load restarts the wait, otherwise count down to zero
	assign next_remain = load_in ? load_val_in :
		((remain_out != '0) ? remain_out - W'(1) : remain_out);

	// busy is registered so the top sees it straight from a flop
	always_ff @(posedge clock_in)
	begin
		if (sys_rst_in)
		begin
			remain_out <= '0;
			busy_out <= 1'b0;
		end
		else
		begin
			remain_out <= next_remain;
			busy_out <= (next_remain != '0);
		end
	end
endmodule
`default_nettype wire

// File: verilog/tcr_i2c_slave.sv
// module: i2c slave bit engine with address match, byte receive and byte transmit
`default_nettype none
`timescale 1ns/10ps
module tcr_i2c_slave #(
	parameter logic [6:0] DEV_ADDR = 7'h00
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic sys_rst_in,
	// bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_oe_out,
	// byte side
	input wire logic accept_in,
	input wire logic [7:0] tx_byte_in,
	output logic rx_valid_out,
	output logic rx_first_out,
	output logic [7:0] rx_byte_out,
	output logic tx_req_out
);
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_ADDR = 3'b001,
		S_ACK = 3'b010,
		S_WR = 3'b011,
		S_RD = 3'b100,
		S_MACK = 3'b101
	} tcr_bus_state_e;

	tcr_bus_state_e state;
	logic scl_q;
	logic sda_q;
	logic [2:0] cnt;
	logic [7:0] shreg;
	logic got;
	logic is_read;
	logic first;
	logic mack;

	// edges and bus conditions, seen against last cycle's levels
	wire scl_rise = scl_in & ~scl_q;
	wire scl_fall = ~scl_in & scl_q;
	wire start_cond = scl_in & scl_q & sda_q & ~sda_in;
	wire stop_cond = scl_in & scl_q & ~sda_q & sda_in;
	wire addr_hit = (shreg[7:1] == DEV_ADDR) & accept_in;
	wire byte_end = scl_fall & got;

	// one process walks the bit sequence; start and stop override any state
	always_ff @(posedge clock_in)
	begin
		if (sys_rst_in)
		begin
			state <= S_IDLE;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			cnt <= 3'h0;
			shreg <= 8'h00;
			got <= 1'b0;
			is_read <= 1'b0;
			first <= 1'b0;
			mack <= 1'b0;
			sda_oe_out <= 1'b0;
			rx_valid_out <= 1'b0;
			rx_first_out <= 1'b0;
			rx_byte_out <= 8'h00;
			tx_req_out <= 1'b0;
		end
		else
		begin
			scl_q <= scl_in;
			sda_q <= sda_in;
			rx_valid_out <= 1'b0;
			tx_req_out <= 1'b0;
			if (start_cond)
			begin
				state <= S_ADDR;
				cnt <= 3'h0;
				got <= 1'b0;
				sda_oe_out <= 1'b0;
			end
			else if (stop_cond)
			begin
				state <= S_IDLE;
				got <= 1'b0;
				sda_oe_out <= 1'b0;
			end
			else
			begin
				unique case (state)
					S_IDLE:
						got <= 1'b0;
					S_ADDR, S_WR:
						if (scl_rise)
						begin
							shreg <= {shreg[6:0], sda_in};
							cnt <= cnt + 3'h1;
							got <= (cnt == 3'h7);
						end
						else if (byte_end)
						begin
							got <= 1'b0;
							if (state == S_WR)
							begin
								rx_valid_out <= 1'b1;
								rx_byte_out <= shreg;
								rx_first_out <= first;
								first <= 1'b0;
								state <= S_ACK;
								sda_oe_out <= 1'b1;
							end
							else if (addr_hit)
							begin
								is_read <= shreg[0];
								first <= ~shreg[0];
								state <= S_ACK;
								sda_oe_out <= 1'b1;
							end
							else
								state <= S_IDLE; // busy or foreign address: no ack
						end
					S_ACK:
						if (scl_fall)
						begin
							cnt <= 3'h0;
							if (is_read)
							begin
								shreg <= tx_byte_in;
								tx_req_out <= 1'b1;
								sda_oe_out <= ~tx_byte_in[7];
								state <= S_RD;
							end
							else
							begin
								sda_oe_out <= 1'b0;
								state <= S_WR;
							end
						end
					S_RD:
						if (scl_fall)
						begin
							if (cnt == 3'h7)
							begin
								sda_oe_out <= 1'b0;
								state <= S_MACK;
							end
							else
							begin
								shreg <= {shreg[6:0], 1'b0};
								sda_oe_out <= ~shreg[6];
								cnt <= cnt + 3'h1;
							end
						end
					S_MACK:
						if (scl_rise)
							mack <= ~sda_in;
						else if (scl_fall)
						begin
							cnt <= 3'h0;
							if (mack)
							begin
								shreg <= tx_byte_in;
								tx_req_out <= 1'b1;
								sda_oe_out <= ~tx_byte_in[7];
								state <= S_RD;
							end
							else
								state <= S_IDLE;
						end
					default:
						state <= S_IDLE;
				endcase
			end
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	property p_addr_ack;
		@(posedge clock_in) disable iff (sys_rst_in)
		(state == S_ADDR) && byte_end && addr_hit && !start_cond && !stop_cond
			|=> sda_oe_out && (state == S_ACK);
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");

	property p_busy_nack;
		@(posedge clock_in) disable iff (sys_rst_in)
		(state == S_ADDR) && byte_end && !accept_in && !start_cond && !stop_cond
			|=> !sda_oe_out && (state == S_IDLE) [*1] ##1 !sda_oe_out;
	endproperty
	a_busy_nack: assert property (p_busy_nack) else $error("acked while busy");
endmodule
`default_nettype wire

// File: verilog/tcr_cmd_regs.sv
// module: i2c register file and command interpreter of the touch button controller
`default_nettype none
`timescale 1ns/10ps
module tcr_cmd_regs #(
	parameter logic [6:0] DEV_ADDR = 7'h00,
	parameter logic [7:0] FW_REV = 8'h01, // arbitrary value
	parameter int unsigned NVM_BUSY_CYC = tcr_pkg::NVM_BUSY_CYC,
	parameter int unsigned CFG_BUSY_CYC = tcr_pkg::CFG_BUSY_CYC,
	parameter int unsigned SCAN_START_CYC = tcr_pkg::SCAN_START_CYC,
	parameter int unsigned SCAN_STOP_CYC = tcr_pkg::SCAN_STOP_CYC
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic sys_rst_in,
	// i2c pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	// sensing core
	input wire tcr_pkg::tcr_readback_s readback_in,
	output tcr_pkg::tcr_sleep_s sleep_cfg_out,
	output logic setup_mode_out,
	output logic scan_enable_out,
	output logic busy_out,
	output logic cmd_strobe_out,
	output logic [7:0] cmd_code_out
);
	localparam int BW = tcr_pkg::BUSY_W;
	localparam logic [BW-1:0] NVM_LD = BW'(NVM_BUSY_CYC);
	localparam logic [BW-1:0] CFG_LD = BW'(CFG_BUSY_CYC);
	localparam logic [BW-1:0] START_LD = BW'(SCAN_START_CYC);
	localparam logic [BW-1:0] STOP_LD = BW'(SCAN_STOP_CYC);

	// ****************************************************************
	// elaboration checks
	// ****************************************************************
	// every wait must fit the timer and be at least one cycle
	if (NVM_BUSY_CYC == 0 || NVM_BUSY_CYC >= (1 << BW)) begin : g_bad_nvm
		$error("store wait out of range");
	end
	if (CFG_BUSY_CYC == 0 || CFG_BUSY_CYC >= (1 << BW)) begin : g_bad_cfg
		$error("config wait out of range");
	end
	if (SCAN_START_CYC == 0 || SCAN_START_CYC >= (1 << BW)) begin : g_bad_start
		$error("scan start wait out of range");
	end
	if (SCAN_STOP_CYC == 0 || SCAN_STOP_CYC >= (1 << BW)) begin : g_bad_stop
		$error("scan stop wait out of range");
	end

	// ****************************************************************
	// declarations
	// ****************************************************************
	logic rx_valid;
	logic rx_first;
	logic [7:0] rx_byte;
	logic tx_req;
	logic [7:0] pointer;
	logic [7:0] reply;
	logic [BW-1:0] remain;
	logic [7:0] rd_byte;
	logic [BW-1:0] busy_val;

	// ****************************************************************
	// bus engine
	// ****************************************************************
	// while busy the engine leaves its address unacknowledged
	tcr_i2c_slave #(
		.DEV_ADDR(DEV_ADDR)
	) u_bus (
		.clock_in(clock_in),
		.sys_rst_in(sys_rst_in),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_oe_out(sda_oe_out),
		.accept_in(~busy_out),
		.tx_byte_in(rd_byte),
		.rx_valid_out(rx_valid),
		.rx_first_out(rx_first),
		.rx_byte_out(rx_byte),
		.tx_req_out(tx_req)
	);

	// ****************************************************************
	// address decode
	// ****************************************************************
	// first byte after the address sets the pointer, later bytes are data
	wire wr_en = rx_valid & ~rx_first;
	wire hit_pin = (pointer == tcr_pkg::REG_SLEEP_PIN);
	wire hit_ctrl = (pointer == tcr_pkg::REG_SLEEP_CTRL);
	wire hit_cnt = (pointer == tcr_pkg::REG_SLEEP_CNT);
	wire hit_sel = (pointer == tcr_pkg::REG_BTN_SEL);
	wire hit_cmd = (pointer == tcr_pkg::REG_COMMAND);
	wire is_reserved = ((pointer >= tcr_pkg::RSV_A_FIRST) &&
		(pointer <= tcr_pkg::RSV_A_LAST)) || (pointer == tcr_pkg::RSV_B) ||
		((pointer >= tcr_pkg::RSV_C_FIRST) && (pointer <= tcr_pkg::RSV_C_LAST));
	wire is_readonly = (pointer >= tcr_pkg::REG_BASE_HI) &&
		(pointer <= tcr_pkg::REG_STAT_LO);

	// sleep pin config only takes writes in setup mode
	wire wr_pin = wr_en & hit_pin & setup_mode_out;
	// the rest are open in both modes
	wire wr_ctrl = wr_en & hit_ctrl;
	wire wr_cnt = wr_en & hit_cnt;
	wire wr_sel = wr_en & hit_sel;
	wire wr_cmd = wr_en & hit_cmd;

	// ****************************************************************
	// command decode
	// ****************************************************************
	wire c_nvm = (rx_byte == tcr_pkg::CMD_STORE) ||
		(rx_byte == tcr_pkg::CMD_FACTORY) || (rx_byte == tcr_pkg::CMD_WR_DEFAULTS);
	wire c_cfg = (rx_byte == tcr_pkg::CMD_RD_DEFAULTS) ||
		(rx_byte == tcr_pkg::CMD_RD_WORKING) || (rx_byte == tcr_pkg::CMD_RECONFIG);
	wire c_start = (rx_byte == tcr_pkg::CMD_SCAN_START);
	wire c_stop = (rx_byte == tcr_pkg::CMD_SCAN_STOP);
	// codes past the last one, and reconfigure outside setup, do nothing
	wire cmd_known = (rx_byte <= tcr_pkg::CMD_SCAN_STATUS);
	wire cmd_ok = wr_cmd & cmd_known &
		((rx_byte != tcr_pkg::CMD_RECONFIG) | setup_mode_out);

	// wait each command leaves the device unreachable
	assign busy_val = c_nvm ? NVM_LD :
		c_cfg ? CFG_LD :
		c_start ? START_LD :
		c_stop ? STOP_LD :
		'0;

	// ****************************************************************
	// busy timer
	// ****************************************************************
	tcr_busy_timer #(
		.W(BW)
	) u_busy (
		.clock_in(clock_in),
		.sys_rst_in(sys_rst_in),
		.load_in(cmd_ok && (busy_val != '0)),
		.load_val_in(busy_val),
		.busy_out(busy_out),
		.remain_out(remain)
	);

	// ****************************************************************
	// read selection
	// ****************************************************************
	// sensor bytes are passed live; reserved and unmapped read zero
	function automatic logic [7:0] rd_mux(input logic [7:0] a,
		input tcr_pkg::tcr_sleep_s s, input tcr_pkg::tcr_readback_s r,
		input logic [7:0] rep);
		logic [7:0] v;
		v = tcr_pkg::RESET_BYTE;
		unique case (a)
			tcr_pkg::REG_SLEEP_PIN: v = s.pin_config;
			tcr_pkg::REG_SLEEP_CTRL: v = s.control;
			tcr_pkg::REG_SLEEP_CNT: v = s.standalone_counter;
			tcr_pkg::REG_BTN_SEL: v = s.button_select;
			tcr_pkg::REG_BASE_HI: v = r.baseline[15:8];
			tcr_pkg::REG_BASE_LO: v = r.baseline[7:0];
			tcr_pkg::REG_DIFF_HI: v = r.difference[15:8];
			tcr_pkg::REG_DIFF_LO: v = r.difference[7:0];
			tcr_pkg::REG_RAW_HI: v = r.raw_count[15:8];
			tcr_pkg::REG_RAW_LO: v = r.raw_count[7:0];
			tcr_pkg::REG_STAT_HI: v = r.sensor_state[15:8];
			tcr_pkg::REG_STAT_LO: v = r.sensor_state[7:0];
			tcr_pkg::REG_COMMAND: v = rep;
			default: v = tcr_pkg::RESET_BYTE;
		endcase
		return v;
	endfunction

	assign rd_byte = rd_mux(pointer, sleep_cfg_out, readback_in, reply);

	// ****************************************************************
	// pointer
	// ****************************************************************
	// advances after each data byte in either direction
	always_ff @(posedge clock_in)
	begin
		if (sys_rst_in)
			pointer <= tcr_pkg::RESET_BYTE;
		else if (rx_valid)
			pointer <= rx_first ? rx_byte : pointer + 8'h01;
		else if (tx_req)
			pointer <= pointer + 8'h01;
	end

	// ****************************************************************
	// sleep and selection registers
	// ****************************************************************
	// read-back and reserved addresses have no storage, so writes vanish
	always_ff @(posedge clock_in)
	begin
		if (sys_rst_in)
			sleep_cfg_out <= '0;
		else
		begin
			if (wr_pin)
				sleep_cfg_out.pin_config <= rx_byte;
			if (wr_ctrl)
				sleep_cfg_out.control <= rx_byte;
			if (wr_cnt)
				sleep_cfg_out.standalone_counter <= rx_byte;
			if (wr_sel)
				sleep_cfg_out.button_select <= rx_byte;
		end
	end

	// ****************************************************************
	// command execution
	// ****************************************************************
	// mode and scan state change on the acknowledged command byte
	always_ff @(posedge clock_in)
	begin
		if (sys_rst_in)
		begin
			setup_mode_out <= 1'b0;
			scan_enable_out <= 1'b0;
			reply <= tcr_pkg::RESET_BYTE;
			cmd_strobe_out <= 1'b0;
			cmd_code_out <= tcr_pkg::RESET_BYTE;
			sda_out <= 1'b0;
		end
		else
		begin
			sda_out <= 1'b0; // open drain: only ever pulls low
			cmd_strobe_out <= cmd_ok;
			if (cmd_ok)
				cmd_code_out <= rx_byte;
			if (cmd_ok && (rx_byte == tcr_pkg::CMD_NORMAL))
				setup_mode_out <= 1'b0;
			if (cmd_ok && (rx_byte == tcr_pkg::CMD_SETUP))
				setup_mode_out <= 1'b1;
			if (cmd_ok && c_start)
				scan_enable_out <= 1'b1;
			if (cmd_ok && c_stop)
				scan_enable_out <= 1'b0;
			if (cmd_ok && (rx_byte == tcr_pkg::CMD_FW_REV))
				reply <= FW_REV;
			if (cmd_ok && (rx_byte == tcr_pkg::CMD_SCAN_STATUS))
				reply <= {7'h00, scan_enable_out};
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	sequence s_cmd(logic [7:0] c);
		cmd_ok && (rx_byte == c);
	endsequence

	sequence s_held_busy(logic [BW-1:0] n);
		(remain == n) ##1 busy_out [*8];
	endsequence

	property p_nvm_wait;
		@(posedge clock_in) disable iff (sys_rst_in)
		s_cmd(tcr_pkg::CMD_STORE) |=> s_held_busy(NVM_LD);
	endproperty
	a_nvm_wait: assert property (p_nvm_wait) else $error("store wait wrong");

	property p_cfg_wait;
		@(posedge clock_in) disable iff (sys_rst_in)
		s_cmd(tcr_pkg::CMD_RD_WORKING) |=> s_held_busy(CFG_LD);
	endproperty
	a_cfg_wait: assert property (p_cfg_wait) else $error("config read wait wrong");

	property p_scan_start;
		@(posedge clock_in) disable iff (sys_rst_in)
		s_cmd(tcr_pkg::CMD_SCAN_START) |=> scan_enable_out && (remain == START_LD);
	endproperty
	a_scan_start: assert property (p_scan_start) else $error("scan start wrong");

	property p_mode_switch;
		@(posedge clock_in) disable iff (sys_rst_in)
		s_cmd(tcr_pkg::CMD_SETUP) |=> setup_mode_out && !busy_out ##1
			!busy_out;
	endproperty
	a_mode_switch: assert property (p_mode_switch) else $error("setup entry wrong");

	property p_pin_locked;
		@(posedge clock_in) disable iff (sys_rst_in)
		wr_en && hit_pin && !setup_mode_out |=> $stable(sleep_cfg_out.pin_config);
	endproperty
	a_pin_locked: assert property (p_pin_locked) else $error("pin config written");

	property p_open_write;
		@(posedge clock_in) disable iff (sys_rst_in)
		wr_en && hit_cnt && !setup_mode_out |=>
			(sleep_cfg_out.standalone_counter == $past(rx_byte));
	endproperty
	a_open_write: assert property (p_open_write) else $error("counter not written");

	property p_rw_ctrl;
		@(posedge clock_in) disable iff (sys_rst_in)
		wr_en && hit_ctrl |=>
			(sleep_cfg_out.control == $past(rx_byte));
	endproperty
	a_rw_ctrl: assert property (p_rw_ctrl) else $error("control readback wrong");

	property p_reserved_zero;
		@(posedge clock_in) disable iff (sys_rst_in)
		tx_req ##0 $past(is_reserved) |-> $past(rd_byte) == tcr_pkg::RESET_BYTE;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved not zero");

	property p_ro_ignored;
		@(posedge clock_in) disable iff (sys_rst_in)
		wr_en && (is_readonly || is_reserved) |=> $stable(sleep_cfg_out) &&
			$stable(setup_mode_out) && !cmd_strobe_out;
	endproperty
	a_ro_ignored: assert property (p_ro_ignored) else $error("read-only write took");

	property p_bad_cmd;
		@(posedge clock_in) disable iff (sys_rst_in)
		wr_cmd && !cmd_known |=> !cmd_strobe_out && $stable(setup_mode_out) &&
			$stable(scan_enable_out) && $stable(busy_out);
	endproperty
	a_bad_cmd: assert property (p_bad_cmd) else $error("unknown code acted on");
endmodule
`default_nettype wire

// File: sim/tcr_host.sv
// host i2c master model that drives the touch command block
`timescale 1ns/10ps
`default_nettype none
module tcr_host #(
	parameter logic [6:0] ADDR = 7'h2A
) (
	// clock
	input wire logic clock_in,
	// bus: sda is resolved with a pull-up outside
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_low_out
);
	initial
	begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end
	// three cycles per level, above the two-cycle minimum the device needs
	task automatic hold();
		repeat (3) @(negedge clock_in);
	endtask
	// start or repeated start
	task automatic start();
		sda_low_out = 1'b0;
		hold();
		scl_out = 1'b1;
		hold();
		sda_low_out = 1'b1;
		hold();
		scl_out = 1'b0;
		hold();
	endtask
	task automatic stop();
		sda_low_out = 1'b1;
		hold();
		scl_out = 1'b1;
		hold();
		sda_low_out = 1'b0;
		hold();
	endtask
	// eight bits out, then a ninth; nine high releases the line
	task automatic xfer(input logic [7:0] d, input logic nine, output logic [7:0] q,
		output logic ack);
		logic [8:0] bits;
		bits = {d, nine};
		for (int i = 8; i >= 0; i--)
		begin
			sda_low_out = ~bits[i];
			hold();
			scl_out = 1'b1;
			hold();
			if (i > 0) q[i-1] = sda_in;
			else ack = ~sda_in;
			scl_out = 1'b0;
			hold();
		end
	endtask
	// address, register, one data byte, in that order
	task automatic wr(input logic [7:0] r, input logic [7:0] d, output logic ack);
		logic [7:0] q;
		logic a;
		start();
		xfer({ADDR, 1'b0}, 1'b1, q, ack);
		xfer(r, 1'b1, q, a);
		xfer(d, 1'b1, q, a);
		stop();
	endtask
	// pointer write, repeated start, one byte read and refused with a nack
	task automatic rd(input logic [7:0] r, output logic [7:0] d);
		logic [7:0] q;
		logic a;
		start();
		xfer({ADDR, 1'b0}, 1'b1, q, a);
		xfer(r, 1'b1, q, a);
		start();
		xfer({ADDR, 1'b1}, 1'b1, q, a);
		xfer(8'hFF, 1'b1, d, a);
		stop();
	endtask
endmodule
`default_nettype wire

// File: sim/tcr_cmd_regs_test.sv
// self-checking bench of the touch command block
`timescale 1ns/10ps
`default_nettype none
module tcr_cmd_regs_test;
	logic clock_in, sys_rst_in, scl, host_low, sda_out, sda_oe, setup, scan, busy, strobe, a;
	logic [7:0] code, q, n_busy, n_strobe;
	int num_errors = 0;
	int total_checks = 0;
	tcr_pkg::tcr_readback_s rb;
	tcr_pkg::tcr_sleep_s cfg;
	// pull-up: high unless someone pulls low
	wire sda = ~(host_low | sda_oe);
	// register rows: address, written byte, byte read back
	logic [23:0] regs [10] = '{24'h7FA5A5, 24'h803C3C, 24'h810F0F, 24'h7E5500, 24'h82FF11,
		24'h850044, 24'h890088, 24'h757700, 24'h7D7700, 24'h8D7700};
	// command rows: code, busy cycles, setup mode nibble, scan nibble
	// store wait outlasts a whole following address byte, so the refusal can be seen
	logic [23:0] cmds [11] = '{24'h080010, 24'h070000, 24'h091E01, 24'h0A1900, 24'h01C800,
		24'h02C800, 24'h03C800, 24'h041400, 24'h051400, 24'h000000, 24'h0B0000};
	tcr_host host (.clock_in(clock_in), .sda_in(sda), .scl_out(scl),
		.sda_low_out(host_low));
	tcr_cmd_regs #(.DEV_ADDR(7'h2A), .NVM_BUSY_CYC(200), .CFG_BUSY_CYC(20),
		.SCAN_START_CYC(30), .SCAN_STOP_CYC(25)) dut (.clock_in(clock_in),
		.sys_rst_in(sys_rst_in), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe_out(sda_oe), .readback_in(rb), .sleep_cfg_out(cfg), .setup_mode_out(setup),
		.scan_enable_out(scan), .busy_out(busy), .cmd_strobe_out(strobe),
		.cmd_code_out(code));
	initial
	begin
		clock_in = 1'b0;
		forever #20 clock_in = ~clock_in;
	end
	// busy cycles and strobes counted on the sampling edge
	always @(posedge clock_in)
	begin
		if (busy === 1'b1) n_busy <= n_busy + 8'h01;
		if (strobe === 1'b1) n_strobe <= n_strobe + 8'h01;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		if (num_errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// bounded wait for the device to become reachable again
	task automatic idle();
		repeat (200) if (busy !== 1'b0) @(negedge clock_in);
	endtask
	// watchdog well beyond the expected run
	initial
	begin
		#2400000;
		num_errors++;
		finish_test();
	end
	initial
	begin
		rb = 64'h1122334455667788;
		sys_rst_in = 1'b1;
		repeat (12) @(negedge clock_in);
		sys_rst_in = 1'b0;
		repeat (2) @(negedge clock_in);
		check(cfg[31:24], 8'h00);
		check(setup, 1'b0);
		check(sda_out, 8'h00);
		foreach (regs[i])
		begin
			host.wr(regs[i][23:16], regs[i][15:8], a);
			check(a, 1'b1);
			host.rd(regs[i][23:16], q);
			check(q, regs[i][7:0]);
		end
		// sensor bytes are read live, so a new value shows at once
		rb = 64'h99AABBCCDDEEF011;
		host.rd(8'h86, q);
		check(q, 8'hDD);
		foreach (cmds[i])
		begin
			n_busy = 8'h00;
			n_strobe = 8'h00;
			host.wr(8'hA0, cmds[i][23:16], a);
			idle();
			check(n_busy, cmds[i][15:8]);
			check(n_strobe, 8'h01);
			check(code, cmds[i][23:16]);
			check(setup, cmds[i][4]);
			check(scan, cmds[i][0]);
		end
		// address refused while busy, and the write behind it lost
		host.wr(8'hA0, 8'h01, a);
		host.wr(8'h7F, 8'h00, a);
		check(a, 1'b0);
		idle();
		host.rd(8'h7F, q);
		check(q, 8'hA5);
		// reconfigure outside setup and an undefined code do nothing
		n_strobe = 8'h00;
		host.wr(8'hA0, 8'h06, a);
		host.wr(8'hA0, 8'h0C, a);
		check(n_strobe, 8'h00);
		check(busy, 1'b0);
		// in setup mode the sleep pin register takes writes
		host.wr(8'hA0, 8'h08, a);
		host.wr(8'h7E, 8'h5A, a);
		host.rd(8'h7E, q);
		check(q, 8'h5A);
		check(cfg[31:24], 8'h5A);
		// reconfigure is honoured in setup mode and blocks like a config read
		n_busy = 8'h00;
		host.wr(8'hA0, 8'h06, a);
		idle();
		check(n_busy, 8'h14);
		check(code, 8'h06);
		host.wr(8'hA0, 8'h00, a);
		host.rd(8'hA0, q);
		check(q, 8'h01);
		// reset in mid-run drops setup mode and clears the registers
		sys_rst_in = 1'b1;
		repeat (2) @(negedge clock_in);
		sys_rst_in = 1'b0;
		repeat (2) @(negedge clock_in);
		check(setup, 1'b0);
		check(cfg[31:24], 8'h00);
		host.rd(8'h7F, q);
		check(q, 8'h00);
		finish_test();
	end
endmodule
`default_nettype wire
